// ===== rtl/scan_tap_pkg.sv
// Purpose: Constants and types for the boundary-scan test access port.
// Assumes: One system clock samples the test pins; no software registers.
// Notes: Identification fields other than bit 0 are arbitrary values.
// Notes on behaviour
// R1: EXTEST captures I/O ring into boundary register
// R2: IDCODE loads ID, selects ID register
// R3: SAMPLE Z captures ring, forces outputs high-Z
// R4: SAMPLE/PRELOAD captures ring, memory unaffected
// R5: BYPASS selects one-bit bypass register
// R6: Controller never loads reserved codes (the code loads any shifted code at Update-IR, reserved ones included)
// R7: ID register 32 bits, bit 0 one
// R8: ID bits 31:29 hold revision
// R9: Depth, type and width codes are constants
// R10: ID bits 11:1 hold manufacturer code
// R11: Boundary register is 89 cells long
// R12: Instruction register three bits wide
// R13: IDCODE current after reset and test-logic-reset
// R14: Cell 89 enables outputs under EXTEST, presets high
// R15: Standard sixteen-state controller on test clock rises
package scan_tap_pkg;
  // ****************************************
  // Widths and instruction codes
  // ****************************************
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int BSR_W = 89;
  localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
  localparam logic [IR_W-1:0] INS_SAMPLE_Z = 3'h2;
  localparam logic [IR_W-1:0] INS_SAMPLE_PRELOAD = 3'h4;
  localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;
  // Capture pattern of the instruction register (low bits 01)
  localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;
  // ****************************************
  // Identification fields (values arbitrary)
  // ****************************************
  localparam logic [2:0] ID_REVISION = 3'h0;
  localparam logic [4:0] ID_DEPTH = 5'h03;
  localparam logic [5:0] ID_TYPE = 6'h02;
  localparam logic [5:0] ID_WIDTH = 6'h05;
  localparam logic [10:0] ID_MAKER = 11'h055;
  localparam logic ID_PRESENT = 1'h1;
  // Index of the output-bus enable cell
  localparam int OE_CELL = BSR_W - 1;
  // ****************************************
  // Controller states and pin bundle
  // ****************************************
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } tap_state_t;
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } tap_pins_t;
endpackage

// ===== rtl/scan_tap.sv
// Purpose: Boundary-scan TAP with instruction, bypass, ID and boundary registers.
// Assumes: Test clock slower than sys_clk/4; sampled via two flip-flops.
// Notes: Test data out changes on the falling test-clock edge.
`timescale 1ns/1ps
module scan_tap (
  input wire logic sys_clk,
  input wire logic rst,
  input wire scan_tap_pkg::tap_pins_t pins, // Test clock, mode select, data in
  input wire logic [scan_tap_pkg::BSR_W-1:0] ring_in, // Live I/O ring levels
  output logic tdo, // Serial data out
  output logic tdo_oe, // High while shifting
  output logic [scan_tap_pkg::BSR_W-1:0] ring_out, // Preloaded cell outputs
  output logic extest_active, // Cells drive pins
  output logic out_bus_en, // Memory output drivers enabled
  output logic [scan_tap_pkg::IR_W-1:0] cur_ins // Current instruction
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  scan_tap_pkg::tap_pins_t pins_m; // First stage, read only by stage two
  scan_tap_pkg::tap_pins_t pins_s; // Second stage
  logic tck_d; // Previous synchronised test clock
  logic [scan_tap_pkg::BSR_W-1:0] ring_m; // Ring first stage, read only by stage two
  logic [scan_tap_pkg::BSR_W-1:0] ring_s; // Ring second stage, what capture sees
  // Two flip-flops per pin; the ring levels move with the memory's own clock
  always_ff @(posedge sys_clk) begin
    pins_m <= pins;
    pins_s <= pins_m;
    tck_d <= pins_s.tck;
    ring_m <= ring_in;
    ring_s <= ring_m;
  end
  wire tck_rise = pins_s.tck & ~tck_d;
  wire tck_fall = ~pins_s.tck & tck_d;

  // ****************************************
  // Controller state machine
  // ****************************************
  scan_tap_pkg::tap_state_t state; // Present controller state
  scan_tap_pkg::tap_state_t next_state; // Successor for sampled mode select
  // Standard sixteen-state transitions (see R15)
  always_comb begin
    case (state)
      scan_tap_pkg::TLR: next_state = pins_s.tms ? scan_tap_pkg::TLR : scan_tap_pkg::RTI;
      scan_tap_pkg::RTI: next_state = pins_s.tms ? scan_tap_pkg::SEL_DR : scan_tap_pkg::RTI;
      scan_tap_pkg::SEL_DR: next_state = pins_s.tms ? scan_tap_pkg::SEL_IR : scan_tap_pkg::CAP_DR;
      scan_tap_pkg::CAP_DR: next_state = pins_s.tms ? scan_tap_pkg::EX1_DR : scan_tap_pkg::SHF_DR;
      scan_tap_pkg::SHF_DR: next_state = pins_s.tms ? scan_tap_pkg::EX1_DR : scan_tap_pkg::SHF_DR;
      scan_tap_pkg::EX1_DR: next_state = pins_s.tms ? scan_tap_pkg::UPD_DR : scan_tap_pkg::PAU_DR;
      scan_tap_pkg::PAU_DR: next_state = pins_s.tms ? scan_tap_pkg::EX2_DR : scan_tap_pkg::PAU_DR;
      scan_tap_pkg::EX2_DR: next_state = pins_s.tms ? scan_tap_pkg::UPD_DR : scan_tap_pkg::SHF_DR;
      scan_tap_pkg::UPD_DR: next_state = pins_s.tms ? scan_tap_pkg::SEL_DR : scan_tap_pkg::RTI;
      scan_tap_pkg::SEL_IR: next_state = pins_s.tms ? scan_tap_pkg::TLR : scan_tap_pkg::CAP_IR;
      scan_tap_pkg::CAP_IR: next_state = pins_s.tms ? scan_tap_pkg::EX1_IR : scan_tap_pkg::SHF_IR;
      scan_tap_pkg::SHF_IR: next_state = pins_s.tms ? scan_tap_pkg::EX1_IR : scan_tap_pkg::SHF_IR;
      scan_tap_pkg::EX1_IR: next_state = pins_s.tms ? scan_tap_pkg::UPD_IR : scan_tap_pkg::PAU_IR;
      scan_tap_pkg::PAU_IR: next_state = pins_s.tms ? scan_tap_pkg::EX2_IR : scan_tap_pkg::PAU_IR;
      scan_tap_pkg::EX2_IR: next_state = pins_s.tms ? scan_tap_pkg::UPD_IR : scan_tap_pkg::SHF_IR;
      scan_tap_pkg::UPD_IR: next_state = pins_s.tms ? scan_tap_pkg::SEL_DR : scan_tap_pkg::RTI;
      default: next_state = scan_tap_pkg::TLR;
    endcase
  end
  // Advance on each test clock rise
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= scan_tap_pkg::TLR;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // ****************************************
  // Decoding
  // ****************************************
  wire in_tlr = (state == scan_tap_pkg::TLR);
  wire sel_bsr = (cur_ins == scan_tap_pkg::INS_EXTEST) |
                 (cur_ins == scan_tap_pkg::INS_SAMPLE_Z) |
                 (cur_ins == scan_tap_pkg::INS_SAMPLE_PRELOAD); // see R1 see R3 see R4
  wire sel_id = (cur_ins == scan_tap_pkg::INS_IDCODE); // see R2
  wire shift_dr = tck_rise & (state == scan_tap_pkg::SHF_DR);
  wire cap_dr = tck_rise & (state == scan_tap_pkg::CAP_DR);
  wire upd_dr = tck_rise & (state == scan_tap_pkg::UPD_DR);
  wire shift_ir = tck_rise & (state == scan_tap_pkg::SHF_IR);
  // Fixed identification word (see R7 see R8 see R9 see R10)
  wire [scan_tap_pkg::ID_W-1:0] id_word = {scan_tap_pkg::ID_REVISION, scan_tap_pkg::ID_DEPTH,
    scan_tap_pkg::ID_TYPE, scan_tap_pkg::ID_WIDTH, scan_tap_pkg::ID_MAKER,
    scan_tap_pkg::ID_PRESENT};

  // ****************************************
  // Instruction register
  // ****************************************
  logic [scan_tap_pkg::IR_W-1:0] ir_shift; // Three-bit shift stage (see R12)
  // Capture, shift, update; reset makes IDCODE current (see R13)
  always_ff @(posedge sys_clk) begin
    if (rst || (tck_rise && in_tlr)) begin
      ir_shift <= scan_tap_pkg::IR_CAPTURE;
      cur_ins <= scan_tap_pkg::INS_IDCODE; // see R13
    end else if (tck_rise && state == scan_tap_pkg::CAP_IR) begin
      ir_shift <= scan_tap_pkg::IR_CAPTURE;
    end else if (shift_ir) begin
      ir_shift <= {pins_s.tdi, ir_shift[scan_tap_pkg::IR_W-1:1]};
    end else if (tck_rise && state == scan_tap_pkg::UPD_IR) begin
      cur_ins <= ir_shift; // Any shifted code is loaded, reserved ones included (see R6)
    end
  end

  // ****************************************
  // Data registers
  // ****************************************
  logic bypass; // One-bit bypass register (see R5)
  logic [scan_tap_pkg::ID_W-1:0] id_shift; // Identification shift stage
  logic [scan_tap_pkg::BSR_W-1:0] bsr; // Boundary shift stage (see R11)
  // Capture and shift of the data registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bypass <= 1'h0;
      id_shift <= '0;
      bsr <= '0;
    end else if (cap_dr) begin
      bypass <= 1'h0;
      id_shift <= id_word; // see R2
      if (sel_bsr) begin
        bsr <= ring_s; // see R1 see R3 see R4
      end
    end else if (shift_dr) begin
      bypass <= pins_s.tdi; // see R5
      id_shift <= {pins_s.tdi, id_shift[scan_tap_pkg::ID_W-1:1]};
      if (sel_bsr) begin
        bsr <= {pins_s.tdi, bsr[scan_tap_pkg::BSR_W-1:1]};
      end
    end
  end
  // Update stage; output-enable cell presets high (see R14)
  always_ff @(posedge sys_clk) begin
    if (rst || (tck_rise && in_tlr)) begin
      ring_out <= '0;
      ring_out[scan_tap_pkg::OE_CELL] <= 1'h1;
    end else if (upd_dr && sel_bsr) begin
      ring_out <= bsr;
    end
  end

  // ****************************************
  // Serial output and pin control
  // ****************************************
  wire dr_bit = sel_bsr ? bsr[0] : (sel_id ? id_shift[0] : bypass);
  wire shifting = (state == scan_tap_pkg::SHF_DR) | (state == scan_tap_pkg::SHF_IR);
  // Drive data on the falling test clock edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tdo <= 1'h0;
      tdo_oe <= 1'h0;
    end else if (tck_fall) begin
      tdo <= (state == scan_tap_pkg::SHF_IR) ? ir_shift[0] : dr_bit;
      tdo_oe <= shifting;
    end
  end
  assign extest_active = (cur_ins == scan_tap_pkg::INS_EXTEST); // see R1
  // High-Z under SAMPLE Z, cell-controlled under EXTEST (see R3 see R14)
  assign out_bus_en = (cur_ins == scan_tap_pkg::INS_SAMPLE_Z) ? 1'h0 :
                      (extest_active ? ring_out[scan_tap_pkg::OE_CELL] : 1'h1);

  // ****************************************
  // Checks
  // ****************************************
  property p_reset_id;
    @(posedge sys_clk) $rose(rst) |=> (cur_ins == scan_tap_pkg::INS_IDCODE);
  endproperty
  a_reset_id: assert property (p_reset_id) else $error("IDCODE not current after reset"); // see R13
  property p_tlr_id;
    @(posedge sys_clk) disable iff (rst) (tck_rise && in_tlr) |=> sel_id;
  endproperty
  a_tlr_id: assert property (p_tlr_id) else $error("IDCODE not set in reset state"); // see R13
  property p_samplez_hiz;
    @(posedge sys_clk) disable iff (rst)
      (cur_ins == scan_tap_pkg::INS_SAMPLE_Z) |-> !out_bus_en;
  endproperty
  a_samplez_hiz: assert property (p_samplez_hiz) else $error("Outputs not high-Z"); // see R3
  property p_preload_bus;
    @(posedge sys_clk) disable iff (rst)
      (cur_ins == scan_tap_pkg::INS_SAMPLE_PRELOAD || cur_ins == scan_tap_pkg::INS_BYPASS
       || sel_id) |-> out_bus_en;
  endproperty
  a_preload_bus: assert property (p_preload_bus) else $error("Memory output disturbed"); // see R4
  property p_capture_ring;
    @(posedge sys_clk) disable iff (rst) (cap_dr && sel_bsr) |=> (bsr == $past(ring_s));
  endproperty
  a_capture_ring: assert property (p_capture_ring) else $error("Ring not captured"); // see R1
  property p_id_capture;
    @(posedge sys_clk) disable iff (rst) cap_dr |=> (id_shift[0] == 1'h1) &&
      (id_shift[31:29] == scan_tap_pkg::ID_REVISION);
  endproperty
  a_id_capture: assert property (p_id_capture) else $error("ID word wrong"); // see R7
  property p_bypass_shift;
    @(posedge sys_clk) disable iff (rst) shift_dr |=> (bypass == $past(pins_s.tdi));
  endproperty
  a_bypass_shift: assert property (p_bypass_shift) else $error("Bypass not shifting"); // see R5
  property p_extest_cell;
    @(posedge sys_clk) disable iff (rst)
      extest_active |-> (out_bus_en == ring_out[scan_tap_pkg::OE_CELL]);
  endproperty
  a_extest_cell: assert property (p_extest_cell) else $error("Enable cell ignored"); // see R14
  property p_tlr_stays;
    @(posedge sys_clk) disable iff (rst) (tck_rise && in_tlr && pins_s.tms) |=> in_tlr;
  endproperty
  a_tlr_stays: assert property (p_tlr_stays) else $error("Left reset state on high TMS"); // see R15
  // Update-IR makes the shifted code current
  property p_ir_update;
    @(posedge sys_clk) disable iff (rst)
      (tck_rise && state == scan_tap_pkg::UPD_IR) |=> (cur_ins == $past(ir_shift));
  endproperty
  a_ir_update: assert property (p_ir_update) else $error("Instruction not updated"); // see R12
  // Test-logic-reset presets the output-bus enable cell
  property p_tlr_preset;
    @(posedge sys_clk) disable iff (rst) (tck_rise && in_tlr) |=> ring_out[scan_tap_pkg::OE_CELL];
  endproperty
  a_tlr_preset: assert property (p_tlr_preset) else $error("Enable cell not preset"); // see R14
  // Update-DR latches the boundary shift stage into the cell outputs
  property p_ring_update;
    @(posedge sys_clk) disable iff (rst) (upd_dr && sel_bsr) |=> (ring_out == $past(bsr));
  endproperty
  a_ring_update: assert property (p_ring_update) else $error("Preload not latched"); // see R1
  // Output enable follows the shift states at each test clock fall
  property p_oe_track;
    @(posedge sys_clk) disable iff (rst) tck_fall |=> (tdo_oe == $past(shifting));
  endproperty
  a_oe_track: assert property (p_oe_track) else $error("Data out enable wrong"); // see R15
  // Serial data enters the boundary register at its far end
  property p_bsr_shift;
    @(posedge sys_clk) disable iff (rst)
      (shift_dr && sel_bsr) |=> (bsr[scan_tap_pkg::BSR_W-1] == $past(pins_s.tdi));
  endproperty
  a_bsr_shift: assert property (p_bsr_shift) else $error("Boundary not shifting"); // see R11
endmodule

// ===== bench/scan_ctl_model.sv
// Purpose: Boundary-scan controller model that walks the TAP state machine.
// Assumes: Test clock 160 ns, 10 sys_clk low then 10 high.
// Notes: Test data out is taken just before each test clock rise.
`timescale 1ns/1ps
module scan_ctl_model (
  input wire logic sys_clk,
  input wire logic tdo,
  input wire logic tdo_oe,
  output scan_tap_pkg::tap_pins_t pins
);
  // ****************************************
  // Test clock cycles and state walks
  // ****************************************
  logic oe_now; // Data out enable seen before the last rise
  logic oe_all; // Enable seen high on every bit of the last shift
  initial pins = '0;
  // One test clock; mode and data held through the high phase
  task automatic cyc(input logic tms, input logic tdi, output logic seen);
    @(posedge sys_clk);
    pins <= '{tck: 1'b0, tms: tms, tdi: tdi};
    repeat (9) @(posedge sys_clk);
    seen = tdo;
    oe_now = tdo_oe;
    pins.tck <= 1'b1;
    repeat (10) @(posedge sys_clk);
    pins.tck <= 1'b0;
  endtask
  // Shift n bits LSB first, then Update and back to idle
  task automatic shift(input int n, input logic [88:0] din, output logic [88:0] dout);
    logic s;
    dout = '0;
    oe_all = 1'b1;
    for (int i = 0; i < n; i++) begin
      cyc(i == n - 1, din[i], s);
      dout[i] = s;
      oe_all = oe_all & oe_now;
    end
    cyc(1'b1, 1'b0, s);
    cyc(1'b0, 1'b0, s);
  endtask
  // Idle to Shift-DR and through
  task automatic dr(input int n, input logic [88:0] din, output logic [88:0] dout);
    logic s;
    cyc(1'b1, 1'b0, s);
    cyc(1'b0, 1'b0, s);
    cyc(1'b0, 1'b0, s);
    shift(n, din, dout);
  endtask
  // Only implemented codes are loaded by the bench
  task automatic ir(input logic [2:0] code, output logic [88:0] cap);
    logic s;
    cyc(1'b1, 1'b0, s);
    cyc(1'b1, 1'b0, s);
    cyc(1'b0, 1'b0, s);
    cyc(1'b0, 1'b0, s);
    shift(3, {86'h0, code}, cap);
  endtask
  // Five mode-high clocks reach test-logic-reset, then idle
  task automatic reset_tap();
    logic s;
    repeat (5) cyc(1'b1, 1'b0, s);
    cyc(1'b0, 1'b0, s);
  endtask
endmodule

// ===== bench/boundary_scan_tap_registers_tb_top.sv
// Purpose: Self-checking bench for the boundary-scan TAP.
// Assumes: Controller model drives the test pins.
// Notes: Expected values come from the package constants.
`timescale 1ns/1ps
module boundary_scan_tap_registers_tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [88:0] ring_in = '0;
  scan_tap_pkg::tap_pins_t pins;
  logic tdo, tdo_oe, extest_active, out_bus_en;
  logic [88:0] ring_out;
  logic [2:0] cur_ins;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #4 sys_clk = ~sys_clk;
  scan_tap i_dut (.sys_clk(sys_clk), .rst(rst), .pins(pins), .ring_in(ring_in), .tdo(tdo),
    .tdo_oe(tdo_oe), .ring_out(ring_out), .extest_active(extest_active),
    .out_bus_en(out_bus_en), .cur_ins(cur_ins));
  scan_ctl_model i_ctl (.sys_clk(sys_clk), .tdo(tdo), .tdo_oe(tdo_oe), .pins(pins));
  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input string what, input logic [88:0] seen, input logic [88:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures++;
      complete_run();
    end
  end
  // ****************************************
  // Scenarios
  // ****************************************
  // Identification path after reset
  task automatic t_ident();
    logic [88:0] d;
    check("ins", cur_ins, scan_tap_pkg::INS_IDCODE);
    check("oe_cell", ring_out[88], 1'b1);
    i_ctl.reset_tap();
    i_ctl.dr(32, '0, d);
    check("id_bit0", d[0], 1'b1);
    check("id", d[31:0], {scan_tap_pkg::ID_REVISION, scan_tap_pkg::ID_DEPTH,
      scan_tap_pkg::ID_TYPE, scan_tap_pkg::ID_WIDTH, scan_tap_pkg::ID_MAKER, 1'b1});
    check("bus_en", out_bus_en, 1'b1);
  endtask
  // Bypass is one bit that captures zero
  task automatic t_bypass();
    logic [88:0] d;
    i_ctl.ir(scan_tap_pkg::INS_BYPASS, d);
    check("ir_cap", d[2:0], scan_tap_pkg::IR_CAPTURE);
    check("ins", cur_ins, scan_tap_pkg::INS_BYPASS);
    i_ctl.dr(3, 89'h3, d);
    check("bypass", d[2:0], 3'h6);
    check("oe_shift", i_ctl.oe_all, 1'b1);
    check("oe_idle", tdo_oe, 1'b0);
    check("bus_en", out_bus_en, 1'b1);
  endtask
  // Capture, preload and output control per boundary instruction
  task automatic t_boundary();
    logic [2:0] codes [3];
    logic [88:0] d, pat, pre;
    codes = '{scan_tap_pkg::INS_SAMPLE_PRELOAD, scan_tap_pkg::INS_EXTEST,
      scan_tap_pkg::INS_SAMPLE_Z};
    for (int k = 0; k < 3; k++) begin
      pre = {1'b0, {11{8'ha6}}} ^ 89'(k);
      pat = {1'b1, {11{8'h3c}}} ^ {86'h0, codes[k]} ^ (89'h1 << (88 - k));
      @(posedge sys_clk);
      ring_in <= pat;
      i_ctl.ir(codes[k], d);
      check("ins", cur_ins, codes[k]);
      i_ctl.dr(89, pre, d);
      check("capture", d, pat);
      check("preload", ring_out, pre);
      check("extest", extest_active, k == 1);
      check("bus_en", out_bus_en, k == 0);
    end
  endtask
  // Test-logic-reset restores identification and the enable preset
  task automatic t_tlr();
    logic [88:0] d;
    i_ctl.reset_tap();
    check("ins", cur_ins, scan_tap_pkg::INS_IDCODE);
    check("oe_cell", ring_out[88], 1'b1);
    check("bus_en", out_bus_en, 1'b1);
    i_ctl.ir(scan_tap_pkg::INS_EXTEST, d);
    check("extest_preset", extest_active, 1'b1);
    check("bus_en_ext", out_bus_en, 1'b1);
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    t_ident();
    t_bypass();
    t_boundary();
    t_tlr();
    complete_run();
  end
endmodule
